// File: src/dscp_pkg.sv
`default_nettype none
package dscp_pkg;
    // ************************************************************
    // widths and defaults
    // ************************************************************
    localparam int          DSCP_CODE_W       = 10;
    localparam int          DSCP_CTRL_W       = 6;
    localparam int          DSCP_OP_W         = 4;
    localparam int          DSCP_SHIFT_W      = 24;
    localparam int          DSCP_SPI_W        = 16;
    localparam int          DSCP_CNT_W        = 6;
    localparam logic [9:0]  DSCP_CODE_RST     = 10'h000;
    localparam logic [5:0]  DSCP_CTRL_RST     = 6'h00;

    // ************************************************************
    // operation codes
    // ************************************************************
    localparam logic [3:0]  DSCP_OP_NOP       = 4'h0;
    localparam logic [3:0]  DSCP_OP_LOAD_IN   = 4'h1;
    localparam logic [3:0]  DSCP_OP_UPDATE    = 4'h2;
    localparam logic [3:0]  DSCP_OP_LOAD_BOTH = 4'h3;
    localparam logic [3:0]  DSCP_OP_CTRL      = 4'h4;

    // ************************************************************
    // control field positions, taken from code bits 9..4
    // ************************************************************
    localparam int          DSCP_CTRL_RESET   = 5;
    localparam int          DSCP_CTRL_PD_HI   = 4;
    localparam int          DSCP_CTRL_PD_LO   = 3;
    localparam int          DSCP_CTRL_REF     = 2;
    localparam int          DSCP_CTRL_GAIN    = 1;
    localparam int          DSCP_CTRL_CHAIN   = 0;
    localparam int          DSCP_CTRL_LSB     = 4;

    // ************************************************************
    // serial word layouts
    // ************************************************************
    localparam int          DSCP_SPI_OP_MSB   = 15;
    localparam int          DSCP_SPI_OP_LSB   = 12;
    localparam int          DSCP_SPI_CODE_MSB = 11;
    localparam int          DSCP_SPI_CODE_LSB = 2;
    localparam int          DSCP_CH_OP_MSB    = 23;
    localparam int          DSCP_CH_OP_LSB    = 20;
    localparam int          DSCP_CH_CODE_MSB  = 19;
    localparam int          DSCP_CH_CODE_LSB  = 10;
    localparam logic [5:0]  DSCP_SPI_EDGES    = 6'h10;
    localparam logic [5:0]  DSCP_CHAIN_EDGES  = 6'h18;
    localparam logic [5:0]  DSCP_SPI_LAST     = 6'h0F;
    localparam logic [5:0]  DSCP_CNT_MAX      = 6'h3F;

    // ************************************************************
    // two-wire slave
    // ************************************************************
    localparam logic [4:0]  DSCP_I2C_ADDR_HI  = 5'h13;
    localparam logic [3:0]  DSCP_BYTE_BITS    = 4'h8;
    localparam logic [1:0]  DSCP_I2C_BYTES    = 2'h3;
    localparam logic [1:0]  DSCP_BYTE_CMD     = 2'h0;
    localparam logic [1:0]  DSCP_BYTE_HI      = 2'h1;
    localparam int          DSCP_I2C_OP_MSB   = 7;
    localparam int          DSCP_I2C_OP_LSB   = 4;
    localparam int          DSCP_I2C_LO_MSB   = 7;
    localparam int          DSCP_I2C_LO_LSB   = 6;

    // ************************************************************
    // pin bundle order at the synchroniser
    // ************************************************************
    localparam int          DSCP_PIN_N        = 7;
    localparam logic [6:0]  DSCP_PIN_RST      = 7'h7F;
    localparam int          DSCP_PIN_SYNC_N   = 0;
    localparam int          DSCP_PIN_SCLK     = 1;
    localparam int          DSCP_PIN_SDI      = 2;
    localparam int          DSCP_PIN_SCL      = 3;
    localparam int          DSCP_PIN_SDA      = 4;
    localparam int          DSCP_PIN_A0       = 5;
    localparam int          DSCP_PIN_LOAD_N   = 6;

    typedef enum logic [2:0] {
        DSCP_I_IDLE,
        DSCP_I_ADDR,
        DSCP_I_ADDR_ACK,
        DSCP_I_DATA,
        DSCP_I_DATA_ACK,
        DSCP_I_IGNORE
    } dscp_i2c_state_t;
endpackage
`default_nettype wire

// File: src/dscp_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module dscp_pin_sync #(
    parameter int                 WIDTH     = 1,
    parameter logic [WIDTH-1:0]   RESET_VAL = '1
) (
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] pin_lvl
);
    // ************************************************************
    // three stages; level moves only when stages two and three agree
    // ************************************************************
    logic [WIDTH-1:0] stg1_r;
    logic [WIDTH-1:0] stg2_r;
    logic [WIDTH-1:0] stg3_r;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    stg1_r[gi]  <= RESET_VAL[gi];
                    stg2_r[gi]  <= RESET_VAL[gi];
                    stg3_r[gi]  <= RESET_VAL[gi];
                    pin_lvl[gi] <= RESET_VAL[gi];
                end else begin
                    stg1_r[gi] <= pin_in[gi];
                    stg2_r[gi] <= stg1_r[gi];
                    stg3_r[gi] <= stg2_r[gi];
                    if (stg2_r[gi] == stg3_r[gi]) begin
                        pin_lvl[gi] <= stg3_r[gi];
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// File: src/dscp_command_port.sv
// How it works
// - frame opens on select low; shift on falling clock
// - select held low for 16 bits; decode on rise
// - 16 or more edges: keep first sixteen bits
// - fewer than 16 edges: drop frame entirely
// - chain mode off at reset; set by bit 6
// - chain: over 24 bits valid, last 24 decoded
// - top four bits select the operation
// - code bits 11..2; control bits 11..6
// - two-wire slave fine at 100 and 400 kHz
// - no ten-bit or general call answer
// - address 10011, select pin, then zero
// - acknowledge matching address on ninth clock
// - address select pin caught at each start
// - command byte, two data bytes, all acknowledged
// - two-wire op in command high nibble
// - two-wire control bits in high byte
// - load input only stages; copy on pin/op2
// - output write also refreshes input register
// - copy command ignores its data bits
// - reset bit restores defaults, self clears
// - reference bit zero keeps reference on
// - load pin ignored during serial access
`timescale 1ns/100ps
`default_nettype none
module dscp_command_port
    import dscp_pkg::*;
(
    input  wire logic                        sys_clk,
    input  wire logic                        arst_n,
    input  wire logic                        sync_n,
    input  wire logic                        sclk,
    input  wire logic                        sdi,
    input  wire logic                        scl,
    input  wire logic                        sda_in,
    output var  logic                        sda_out,
    output var  logic                        sda_oe,
    input  wire logic                        addr_select_pin,
    input  wire logic                        load_output_n,
    output var  logic [dscp_pkg::DSCP_CODE_W-1:0] dac_code,
    output var  logic [dscp_pkg::DSCP_CODE_W-1:0] input_code,
    output var  logic                        powerdown_sel_hi,
    output var  logic                        powerdown_sel_lo,
    output var  logic                        ref_disable,
    output var  logic                        gain_sel,
    output var  logic                        chain_enable
);
    import dscp_pkg::*;

    // ************************************************************
    // pin synchronisers and edge finding
    // ************************************************************
    logic [DSCP_PIN_N-1:0] pins;
    logic [DSCP_PIN_N-1:0] lvl;
    logic [DSCP_PIN_N-1:0] prev_r;
    logic                  sync_fall;
    logic                  sync_rise;
    logic                  sclk_fall;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  i2c_start;
    logic                  i2c_stop;
    logic                  load_fall;

    assign pins[DSCP_PIN_SYNC_N] = sync_n;
    assign pins[DSCP_PIN_SCLK]   = sclk;
    assign pins[DSCP_PIN_SDI]    = sdi;
    assign pins[DSCP_PIN_SCL]    = scl;
    assign pins[DSCP_PIN_SDA]    = sda_in;
    assign pins[DSCP_PIN_A0]     = addr_select_pin;
    assign pins[DSCP_PIN_LOAD_N] = load_output_n;

    // all pins share one latency, so data and clock stay aligned
    dscp_pin_sync #(
        .WIDTH     (DSCP_PIN_N),
        .RESET_VAL (DSCP_PIN_RST)
    ) u_sync (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .pin_in  (pins),
        .pin_lvl (lvl)
    );

    // edge memory starts at the idle high level, so leaving reset fakes no edge
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_r <= DSCP_PIN_RST;
        end else begin
            prev_r <= lvl;
        end
    end

    assign sync_fall = prev_r[DSCP_PIN_SYNC_N] & ~lvl[DSCP_PIN_SYNC_N];
    assign sync_rise = ~prev_r[DSCP_PIN_SYNC_N] & lvl[DSCP_PIN_SYNC_N];
    assign sclk_fall = prev_r[DSCP_PIN_SCLK] & ~lvl[DSCP_PIN_SCLK];
    assign scl_rise  = ~prev_r[DSCP_PIN_SCL] & lvl[DSCP_PIN_SCL];
    assign scl_fall  = prev_r[DSCP_PIN_SCL] & ~lvl[DSCP_PIN_SCL];
    // start and stop rely on data being steady while the clock is high
    assign i2c_start = lvl[DSCP_PIN_SCL] & prev_r[DSCP_PIN_SCL] & prev_r[DSCP_PIN_SDA] & ~lvl[DSCP_PIN_SDA];
    assign i2c_stop  = lvl[DSCP_PIN_SCL] & prev_r[DSCP_PIN_SCL] & ~prev_r[DSCP_PIN_SDA] & lvl[DSCP_PIN_SDA];
    assign load_fall = prev_r[DSCP_PIN_LOAD_N] & ~lvl[DSCP_PIN_LOAD_N];

    // ************************************************************
    // three-wire receiver
    // ************************************************************
    logic [DSCP_SHIFT_W-1:0] spi_shift_r;
    logic [DSCP_SPI_W-1:0]   spi_first_r;
    logic [DSCP_CNT_W-1:0]   spi_cnt_r;
    logic                    spi_in_frame;

    // frame state follows the synchronised select level, no extra flop
    assign spi_in_frame = ~lvl[DSCP_PIN_SYNC_N];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            spi_shift_r <= '0;
            spi_cnt_r   <= '0;
        end else if (sync_fall) begin
            // a clock edge in the very cycle select falls is lost; hosts keep a gap
            spi_cnt_r <= '0;
        end else if (spi_in_frame && sclk_fall) begin
            spi_shift_r <= {spi_shift_r[DSCP_SHIFT_W-2:0], lvl[DSCP_PIN_SDI]};
            // saturate so a very long chain frame still counts as long enough
            if (spi_cnt_r != DSCP_CNT_MAX) begin
                spi_cnt_r <= spi_cnt_r + 6'h01;
            end
        end
    end

    // the first sixteen bits are kept aside so later edges cannot push them out
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            spi_first_r <= '0;
        end else if (spi_in_frame && sclk_fall && !sync_fall && spi_cnt_r == DSCP_SPI_LAST) begin
            spi_first_r <= {spi_shift_r[DSCP_SPI_W-2:0], lvl[DSCP_PIN_SDI]};
        end
    end

    // ************************************************************
    // two-wire slave
    // ************************************************************
    dscp_i2c_state_t i2c_state_r;
    logic [7:0]      i2c_shift_r;
    logic [3:0]      i2c_bits_r;
    logic [1:0]      i2c_bytes_r;
    logic            a0_latch_r;
    logic [7:0]      i2c_cmd_r;
    logic [7:0]      i2c_hi_r;
    logic [7:0]      i2c_lo_r;
    logic            i2c_exec_r;
    logic [6:0]      my_addr;

    assign my_addr = {DSCP_I2C_ADDR_HI, a0_latch_r, 1'b0};

    // the select pin is read only at a start, so it may move between transfers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            a0_latch_r <= 1'b0;
        end else if (i2c_start) begin
            a0_latch_r <= lvl[DSCP_PIN_A0];
        end
    end

    // sampling on the fast core clock covers both bus rates with margin
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            i2c_state_r <= DSCP_I_IDLE;
            i2c_shift_r <= '0;
            i2c_bits_r  <= '0;
            i2c_bytes_r <= '0;
            i2c_cmd_r   <= '0;
            i2c_hi_r    <= '0;
            i2c_lo_r    <= '0;
            sda_oe      <= 1'b0;
            i2c_exec_r  <= 1'b0;
        end else begin
            i2c_exec_r <= 1'b0;
            if (i2c_start) begin
                i2c_state_r <= DSCP_I_ADDR;
                i2c_bits_r  <= '0;
                i2c_bytes_r <= '0;
                sda_oe      <= 1'b0;
            end else if (i2c_stop) begin
                i2c_state_r <= DSCP_I_IDLE;
                sda_oe      <= 1'b0;
                // only a complete three-byte write executes; anything else is dropped
                if (i2c_state_r != DSCP_I_IGNORE && i2c_bytes_r == DSCP_I2C_BYTES) begin
                    i2c_exec_r <= 1'b1;
                end
            end else begin
                case (i2c_state_r)
                    DSCP_I_ADDR, DSCP_I_DATA: begin
                        // bits are taken on the clock rise, while the master holds data steady
                        if (scl_rise) begin
                            i2c_shift_r <= {i2c_shift_r[6:0], lvl[DSCP_PIN_SDA]};
                            i2c_bits_r  <= i2c_bits_r + 4'h1;
                        end else if (scl_fall && i2c_bits_r == DSCP_BYTE_BITS) begin
                            if (i2c_state_r == DSCP_I_ADDR) begin
                                // ten-bit headers and the general call never equal my address
                                if (i2c_shift_r[7:1] == my_addr && !i2c_shift_r[0]) begin
                                    i2c_state_r <= DSCP_I_ADDR_ACK;
                                    sda_oe      <= 1'b1;
                                end else begin
                                    i2c_state_r <= DSCP_I_IGNORE;
                                end
                            end else if (i2c_bytes_r != DSCP_I2C_BYTES) begin
                                case (i2c_bytes_r)
                                    DSCP_BYTE_CMD: i2c_cmd_r <= i2c_shift_r;
                                    DSCP_BYTE_HI:  i2c_hi_r  <= i2c_shift_r;
                                    default:       i2c_lo_r  <= i2c_shift_r;
                                endcase
                                i2c_bytes_r <= i2c_bytes_r + 2'h1;
                                i2c_state_r <= DSCP_I_DATA_ACK;
                                sda_oe      <= 1'b1;
                            end else begin
                                // a fourth byte is not ours; leave it unanswered
                                i2c_state_r <= DSCP_I_IGNORE;
                            end
                        end
                    end
                    DSCP_I_ADDR_ACK, DSCP_I_DATA_ACK: begin
                        // release at the end of the ninth clock
                        if (scl_fall) begin
                            sda_oe      <= 1'b0;
                            i2c_state_r <= DSCP_I_DATA;
                            i2c_bits_r  <= '0;
                        end
                    end
                    // foreign traffic is followed silently until the next start or stop
                    DSCP_I_IGNORE: begin
                        sda_oe <= 1'b0;
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // open drain: only ever pulls low
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // ************************************************************
    // frame decode shared by both receivers
    // ************************************************************
    logic                   exec_v;
    logic [DSCP_OP_W-1:0]   exec_op;
    logic [DSCP_CODE_W-1:0] exec_code;
    logic [DSCP_CTRL_W-1:0] exec_ctrl;
    logic                   serial_busy;

    // the three-wire path wins a tie; both buses at once is a misuse
    always_comb begin
        exec_v    = 1'b0;
        exec_op   = DSCP_OP_NOP;
        exec_code = DSCP_CODE_RST;
        exec_ctrl = DSCP_CTRL_RST;
        if (sync_rise) begin
            if (chain_enable) begin
                exec_v    = (spi_cnt_r > DSCP_CHAIN_EDGES);
                exec_op   = spi_shift_r[DSCP_CH_OP_MSB:DSCP_CH_OP_LSB];
                exec_code = spi_shift_r[DSCP_CH_CODE_MSB:DSCP_CH_CODE_LSB];
            end else begin
                exec_v    = (spi_cnt_r >= DSCP_SPI_EDGES);
                exec_op   = spi_first_r[DSCP_SPI_OP_MSB:DSCP_SPI_OP_LSB];
                exec_code = spi_first_r[DSCP_SPI_CODE_MSB:DSCP_SPI_CODE_LSB];
            end
            exec_ctrl = exec_code[DSCP_CODE_W-1:DSCP_CTRL_LSB];
        end else if (i2c_exec_r) begin
            exec_v    = 1'b1;
            exec_op   = i2c_cmd_r[DSCP_I2C_OP_MSB:DSCP_I2C_OP_LSB];
            exec_code = {i2c_hi_r, i2c_lo_r[DSCP_I2C_LO_MSB:DSCP_I2C_LO_LSB]};
            // chain mode is not reachable from this bus; keep what is set
            exec_ctrl = {exec_code[DSCP_CODE_W-1:DSCP_CTRL_LSB+1], chain_enable};
        end
    end

    // a load pulse during any access is lost; the host has to repeat it
    assign serial_busy = spi_in_frame | (i2c_state_r != DSCP_I_IDLE);

    // ************************************************************
    // input, output and control registers
    // ************************************************************
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            input_code       <= DSCP_CODE_RST;
            dac_code         <= DSCP_CODE_RST;
            powerdown_sel_hi <= DSCP_CTRL_RST[DSCP_CTRL_PD_HI];
            powerdown_sel_lo <= DSCP_CTRL_RST[DSCP_CTRL_PD_LO];
            ref_disable      <= DSCP_CTRL_RST[DSCP_CTRL_REF];
            gain_sel         <= DSCP_CTRL_RST[DSCP_CTRL_GAIN];
            chain_enable     <= DSCP_CTRL_RST[DSCP_CTRL_CHAIN];
        end else if (exec_v) begin
            // one execute strobe per frame; a load edge in the same cycle loses
            case (exec_op)
                DSCP_OP_LOAD_IN: begin
                    input_code <= exec_code;
                end
                DSCP_OP_UPDATE: begin
                    dac_code <= input_code;
                end
                DSCP_OP_LOAD_BOTH: begin
                    dac_code   <= exec_code;
                    input_code <= exec_code;
                end
                DSCP_OP_CTRL: begin
                    if (exec_ctrl[DSCP_CTRL_RESET]) begin
                        // the reset bit is never stored, so it reads as cleared at once
                        input_code       <= DSCP_CODE_RST;
                        dac_code         <= DSCP_CODE_RST;
                        powerdown_sel_hi <= DSCP_CTRL_RST[DSCP_CTRL_PD_HI];
                        powerdown_sel_lo <= DSCP_CTRL_RST[DSCP_CTRL_PD_LO];
                        ref_disable      <= DSCP_CTRL_RST[DSCP_CTRL_REF];
                        gain_sel         <= DSCP_CTRL_RST[DSCP_CTRL_GAIN];
                        chain_enable     <= DSCP_CTRL_RST[DSCP_CTRL_CHAIN];
                    end else begin
                        powerdown_sel_hi <= exec_ctrl[DSCP_CTRL_PD_HI];
                        powerdown_sel_lo <= exec_ctrl[DSCP_CTRL_PD_LO];
                        ref_disable      <= exec_ctrl[DSCP_CTRL_REF];
                        gain_sel         <= exec_ctrl[DSCP_CTRL_GAIN];
                        chain_enable     <= exec_ctrl[DSCP_CTRL_CHAIN];
                    end
                end
                default: begin
                    input_code <= input_code;
                end
            endcase
        end else if (load_fall && !serial_busy) begin
            dac_code <= input_code;
        end
    end
endmodule
`default_nettype wire

// File: tb/dscp_chk.sv
`timescale 1ns/100ps
`default_nettype none
module dscp_chk (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       sync_n,
    input  wire logic       scl,
    input  wire logic       sda_out,
    input  wire logic       sda_oe,
    input  wire logic [9:0] dac_code,
    input  wire logic [9:0] input_code,
    input  wire logic       chain_enable
);
    // ****************
    // port relations
    // ****************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    chk_sda_never_high: assert property (sda_out == 1'b0)
        else $error("sda driven high");
    chk_ack_scl_low: assert property ($changed(sda_oe) |-> !scl)
        else $error("ack moved while scl high");
    chk_ack_min_len: assert property ($rose(sda_oe) |-> sda_oe [*8])
        else $error("ack too short");
    chk_ack_bounded: assert property ($rose(sda_oe) |-> ##[1:400] !sda_oe)
        else $error("ack never released");
    chk_output_mirror: assert property ($changed(dac_code) |-> input_code == dac_code)
        else $error("input register not refreshed");
    chk_frame_quiet: assert property (!sync_n [*8] |-> $stable(dac_code) && $stable(input_code))
        else $error("register moved inside a frame");
    chk_ctrl_idle: assert property ($changed(chain_enable) |-> sync_n && scl)
        else $error("chain bit moved during traffic");
    chk_input_after: assert property ($changed(input_code) |-> $past(sync_n, 2))
        else $error("input register moved before frame end");
    // writes run at stop only, never while the slave is still acking
    chk_ack_steady: assert property ($rose(sda_oe) |-> $stable(input_code) [*8])
        else $error("input register moved during ack");
    cov_ack: cover property ($rose(sda_oe));
    cov_load: cover property ($changed(dac_code) && sync_n);
    cov_chain_off: cover property ($fell(chain_enable));
endmodule
bind dscp_command_port dscp_chk CHK (.sys_clk, .arst_n, .sync_n, .scl, .sda_out, .sda_oe,
    .dac_code, .input_code, .chain_enable);
`default_nettype wire

// File: tb/dscp_master.sv
`timescale 1ns/100ps
`default_nettype none
module dscp_master (
    input  wire logic sys_clk,
    input  wire logic sda_in,
    output var  logic sync_n,
    output var  logic sclk,
    output var  logic sdi,
    output var  logic scl,
    output var  logic sda_m
);
    // ****************
    // serial masters
    // ****************
    initial begin
        sync_n = 1'b1;
        sclk = 1'b1;
        sdi = 1'b0;
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic spi(input logic [31:0] v, input int n);
        sync_n <= 1'b0;
        w(4);
        for (int i = n - 1; i >= 0; i--) begin
            sdi <= v[i];
            w(4);
            sclk <= 1'b0;
            w(4);
            sclk <= 1'b1;
        end
        w(4);
        sync_n <= 1'b1;
        // flip sdi so a stale bit never looks held after release
        sdi <= ~sdi;
        w(12);
    endtask
    task automatic tbit(input logic b, input int q, output logic s);
        sda_m <= b;
        w(q);
        scl <= 1'b1;
        w(q);
        s = sda_in;
        w(q);
        scl <= 1'b0;
        w(q);
    endtask
    task automatic i2c(input logic [7:0] a, c, h, l, input int q, output logic [3:0] ak);
        logic s;
        sda_m <= 1'b0;
        w(2 * q);
        scl <= 1'b0;
        w(q);
        ak = 4'h0;
        for (int k = 0; k < 4; k++) begin
            logic [7:0] by;
            by = (k == 0) ? a : (k == 1) ? c : (k == 2) ? h : l;
            for (int i = 7; i >= 0; i--) tbit(by[i], q, s);
            tbit(1'b1, q, s);
            ak[k] = ~s;
        end
        sda_m <= 1'b0;
        w(q);
        scl <= 1'b1;
        w(q);
        sda_m <= 1'b1;
        w(20);
    endtask
endmodule
`default_nettype wire

// File: tb/dscp_command_port_test.sv
`timescale 1ns/100ps
`default_nettype none
module dscp_command_port_test;
    logic       sys_clk, arst_n, sync_n, sclk, sdi, scl, sda_m, sda_out, sda_oe;
    logic       addr_select_pin, load_output_n, powerdown_sel_hi, powerdown_sel_lo;
    logic       ref_disable, gain_sel, chain_enable;
    logic [9:0] dac_code, input_code;
    logic [3:0] ak;
    int         bad_count, checks, cyc;
    logic [7:0] bad [3] = '{8'h00, 8'h99, 8'h9C};
    wire logic  sda_in = sda_m & ~sda_oe;
    dscp_command_port DUT (.sys_clk, .arst_n, .sync_n, .sclk, .sdi, .scl, .sda_in, .sda_out,
        .sda_oe, .addr_select_pin, .load_output_n, .dac_code, .input_code, .powerdown_sel_hi,
        .powerdown_sel_lo, .ref_disable, .gain_sel, .chain_enable);
    dscp_master MST (.sys_clk, .sda_in, .sync_n, .sclk, .sdi, .scl, .sda_m);
    // ****************
    // checks and sequence
    // ****************
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic check(input string n, input logic [9:0] s, e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic regs_are(input logic [9:0] i, d, input logic [4:0] c);
        check("input_code", input_code, i);
        check("dac_code", dac_code, d);
        check("control", {5'h00, powerdown_sel_hi, powerdown_sel_lo, ref_disable, gain_sel,
            chain_enable}, {5'h00, c});
    endtask
    task automatic pulse_load();
        load_output_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        load_output_n <= 1'b1;
        repeat (12) @(posedge sys_clk);
    endtask
    task automatic stop_test();
        if (bad_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        arst_n = 1'b0;
        addr_select_pin = 1'b1;
        load_output_n = 1'b1;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        regs_are(10'h000, 10'h000, 5'h00);
        MST.spi(32'h1A94, 16);
        regs_are(10'h2A5, 10'h000, 5'h00);
        MST.spi(32'h2FFF, 16);
        regs_are(10'h2A5, 10'h2A5, 5'h00);
        MST.spi(32'h1800, 15);
        regs_are(10'h2A5, 10'h2A5, 5'h00);
        MST.spi(32'hD553, 18);
        regs_are(10'h155, 10'h155, 5'h00);
        for (int op = 5; op <= 16; op++) MST.spi({16'h0000, 4'(op % 16), 12'hFFC}, 16);
        regs_are(10'h155, 10'h155, 5'h00);
        MST.spi(32'h47C0, 16);
        regs_are(10'h155, 10'h155, 5'h1F);
        MST.spi(32'h13C3FF, 24);
        regs_are(10'h155, 10'h155, 5'h1F);
        MST.spi(32'h213C3FF, 26);
        regs_are(10'h0F0, 10'h155, 5'h1F);
        fork
            MST.spi(32'h0000000, 26);
            begin
                repeat (40) @(posedge sys_clk);
                pulse_load();
            end
        join
        regs_are(10'h0F0, 10'h155, 5'h1F);
        pulse_load();
        regs_are(10'h0F0, 10'h0F0, 5'h1F);
        MST.spi(32'h1480000, 26);
        regs_are(10'h000, 10'h000, 5'h00);
        MST.i2c(8'h9C, 8'h3F, 8'hAB, 8'hFF, 7, ak);
        check("ack", {6'h00, ak}, 10'h00F);
        regs_are(10'h2AF, 10'h2AF, 5'h00);
        MST.i2c(8'h9C, 8'h40, 8'h50, 8'h00, 25, ak);
        regs_are(10'h2AF, 10'h2AF, 5'h14);
        addr_select_pin <= 1'b0;
        foreach (bad[j]) begin
            MST.i2c(bad[j], 8'h30, 8'h00, 8'h00, 7, ak);
            check("nack", {6'h00, ak}, 10'h000);
        end
        MST.i2c(8'h98, 8'h10, 8'h00, 8'h40, 7, ak);
        regs_are(10'h001, 10'h2AF, 5'h14);
        stop_test();
    end
endmodule
`default_nettype wire
